// [hw/gcu_top.sv]
// companding stage between converter datapath and serial audio port
// What this block does
// - A-law and mu-law companding available on transmit and receive paths.
// - Receive law in bits 4:3, transmit law in bits 2:1 of 0x05.
// - Encode 14-bit mu or 13-bit A linear to 8 bits; decode inverse.
// - Code word is sign, three-bit segment, four-bit mantissa, sign first.
// - Mu-law inverts all eight code bits on encode and decode.
// - A-law inverts even code bits on encode and again on decode.
// - Bit 5 of 0x05 forces 8-bit serial words, ignoring word length.
// - Mu-law follows the G.711 curve with mu of 255.
// - A-law follows the G.711 piecewise curve with A of 87.6.
module gcu_top
   import gcu_pkg::*;
#(
   parameter int FIFO_DEPTH = 16
) (
   input  wire logic        mclk,
   input  wire logic        nrst,
   input  wire logic        reg_wr,
   input  wire logic [6:0]  reg_addr,
   input  wire logic [8:0]  reg_wdata,
   output logic      [8:0]  reg_rdata,
   input  wire logic [1:0]  serial_word_length,
   output logic      [5:0]  word_bits,
   output logic             adc_dac_loop,
   input  wire logic        adc_valid,
   output logic             adc_ready,
   input  wire logic [15:0] adc_data,
   output logic             tx_valid,
   input  wire logic        tx_ready,
   output logic      [15:0] tx_data,
   input  wire logic        rx_valid,
   output logic             rx_ready,
   input  wire logic [15:0] rx_data,
   output logic             dac_valid,
   input  wire logic        dac_ready,
   output logic      [15:0] dac_data
);
`include "gcu_defs.svh"

   logic [5:0]  ctrl;
   logic [5:0]  next_ctrl;
   logic [8:0]  next_rdata;
   logic [5:0]  next_bits;
   logic        next_dvalid;
   logic [15:0] next_ddata;
   logic [15:0] enc_word;
   logic [15:0] dec_word;
   logic        ctrl_hit;
   logic        rx_take;
   gcu_law_t    adc_law;
   gcu_law_t    dac_law;

   // ==========================================================
   // control register
   assign ctrl_hit = reg_wr && (reg_addr == `GCU_CTRL_ADDR);
   assign adc_law  = gcu_law_t'(ctrl[`GCU_ADC_HI:`GCU_ADC_LO]);
   assign dac_law  = gcu_law_t'(ctrl[`GCU_DAC_HI:`GCU_DAC_LO]);

   // only the low six bits are storage; the top three are wired to zero
   always_comb begin
      next_ctrl  = ctrl_hit ? reg_wdata[5:0] : ctrl;
      next_rdata = 9'h000;
      if (reg_addr == `GCU_CTRL_ADDR) begin
         next_rdata = {3'b000, ctrl};
      end
   end

   // ==========================================================
   // serial word length; the force wins over the programmed length
   always_comb begin
      if (ctrl[`GCU_B8_BIT]) begin
         next_bits = `GCU_BITS_8;
      end else begin
         case (serial_word_length)
            2'b00:   next_bits = `GCU_BITS_16;
            2'b01:   next_bits = `GCU_BITS_20;
            2'b10:   next_bits = `GCU_BITS_24;
            default: next_bits = `GCU_BITS_32;
         endcase
      end
   end

   // register stage for control, readback and word length
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         ctrl         <= `GCU_CTRL_RESET;
         reg_rdata    <= 9'h000;
         word_bits    <= `GCU_BITS_16;
         adc_dac_loop <= 1'b0;
      end else begin
         ctrl         <= next_ctrl;
         reg_rdata    <= next_rdata;
         word_bits    <= next_bits;
         adc_dac_loop <= next_ctrl[`GCU_LOOP_BIT];
      end
   end

   // ==========================================================
   // shared law engine, one encoder and one decoder
   gcu_law u_law (
      .tx_law  (adc_law),
      .lin_in  (adc_data),
      .enc_out (enc_word),
      .rx_law  (dac_law),
      .code_in (rx_data),
      .dec_out (dec_word)
   );

   // ==========================================================
   // transmit: encoded words queue up for the serial port; a full
   // queue stalls the converter side through adc_ready
   gcu_fifo #(
      .WIDTH (16),
      .DEPTH (FIFO_DEPTH)
   ) u_txq (
      .mclk      (mclk),
      .nrst      (nrst),
      .in_valid  (adc_valid),
      .in_ready  (adc_ready),
      .in_data   (enc_word),
      .out_valid (tx_valid),
      .out_ready (tx_ready),
      .out_data  (tx_data)
   );

   // ==========================================================
   // receive: one skid-free holding register toward the dac
   assign rx_ready = !dac_valid || dac_ready;
   assign rx_take  = rx_valid && rx_ready;
   always_comb begin
      next_dvalid = rx_take || (dac_valid && !dac_ready);
      next_ddata  = rx_take ? dec_word : dac_data;
   end

   always_ff @(posedge mclk) begin
      if (!nrst) begin
         dac_valid <= 1'b0;
         dac_data  <= 16'h0000;
      end else begin
         dac_valid <= next_dvalid;
         dac_data  <= next_ddata;
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!nrst);

   a_ctrl_reset_zero: assert property (
      disable iff (1'b0) !nrst |=> (ctrl == 6'h00)
   ) else $error("control register not zero after reset");

   a_rdata_top_zero: assert property (
      reg_rdata[8:6] == 3'b000
   ) else $error("upper control bits read nonzero");

   a_sel_write_read: assert property (
      ctrl_hit |=> (ctrl == $past(reg_wdata[5:0]))
   ) else $error("select fields not stored");

   a_sel_readback: assert property (
      ctrl_hit ##1 (reg_addr == `GCU_CTRL_ADDR)
      |=> (reg_rdata[5:0] == $past(reg_wdata[5:0], 2))
   ) else $error("written control value not read back");

   a_word8_force: assert property (
      ctrl[`GCU_B8_BIT] |=> (word_bits == 6'h08)
   ) else $error("eight bit word not forced");

   a_word_len_pass: assert property (
      (!ctrl[`GCU_B8_BIT] && serial_word_length == 2'b10)
      |=> (word_bits == 6'h18)
   ) else $error("programmed word length not honoured");

   a_off_passthru: assert property (
      (adc_law == LAW_OFF) |-> (enc_word == adc_data)
   ) else $error("companding off altered transmit data");

   a_mu_zero_code: assert property (
      (adc_law == LAW_MU && adc_data == 16'h0000)
      |-> (enc_word == 16'hFF00)
   ) else $error("mu-law zero not fully inverted");

   a_mu_full_scale: assert property (
      (adc_law == LAW_MU && adc_data == 16'h7FFF)
      |-> (enc_word == 16'h8000)
   ) else $error("mu-law positive full scale wrong");

   a_mu_sign_first: assert property (
      (adc_law == LAW_MU && adc_data[15]) |-> !enc_word[15]
   ) else $error("mu-law sign bit misplaced");

   a_alaw_zero_code: assert property (
      (adc_law == LAW_A && adc_data == 16'h0000)
      |-> (enc_word == 16'hD500)
   ) else $error("a-law even bit inversion wrong");

   a_mu_decode_zero: assert property (
      (rx_take && dac_law == LAW_MU && rx_data[15:8] == 8'hFF)
      |=> (dac_valid && dac_data == 16'h0000)
   ) else $error("mu-law decode of idle code wrong");

   a_alaw_decode_min: assert property (
      (rx_take && dac_law == LAW_A && rx_data[15:8] == 8'hD5)
      |=> (dac_data == 16'h0008)
   ) else $error("a-law decode of smallest code wrong");

   a_dac_hold_stall: assert property (
      (dac_valid && !dac_ready) |=> (dac_valid && $stable(dac_data))
   ) else $error("receive word dropped under stall");

   a_tx_hold_stall: assert property (
      (tx_valid && !tx_ready) |=> (tx_valid && $stable(tx_data))
   ) else $error("transmit word dropped under stall");

   // ==========================================================
   // readback, reset state, stream handshake and codec value checks
   a_loop_mirror: assert property (
      ctrl_hit |=> (adc_dac_loop == $past(reg_wdata[0]))
   ) else $error("loop bit output does not follow control");

   a_unmapped_zero: assert property (
      (reg_addr != `GCU_CTRL_ADDR) |=> (reg_rdata == 9'h000)
   ) else $error("unmapped address reads nonzero");

   a_reset_state: assert property (
      disable iff (1'b0) !nrst |=> (reg_rdata == 9'h000 && !dac_valid)
   ) else $error("readback or receive valid not cleared by reset");

   a_rx_ready_rule: assert property (
      (dac_valid && !dac_ready) |-> !rx_ready
   ) else $error("receive side accepts while output stalled");

   a_dac_accept: assert property (
      rx_take |=> dac_valid
   ) else $error("accepted receive word not presented");

   a_rx_off_pass: assert property (
      (rx_take && (dac_law == LAW_OFF || dac_law == LAW_RSV))
      |=> (dac_data == $past(rx_data))
   ) else $error("companding off altered receive data");

   a_tx_rsv_pass: assert property (
      (adc_law == LAW_RSV) |-> (enc_word == adc_data)
   ) else $error("reserved select altered transmit data");

   a_code_low_zero: assert property (
      (adc_law == LAW_MU || adc_law == LAW_A) |-> (enc_word[7:0] == 8'h00)
   ) else $error("code word not msb aligned");

   a_alaw_sign_pos: assert property (
      (adc_law == LAW_A && !adc_data[15]) |-> enc_word[15]
   ) else $error("a-law sign bit of positive sample wrong");

   a_mu_neg_full: assert property (
      (adc_law == LAW_MU && adc_data == 16'h8000)
      |-> (enc_word == 16'h0000)
   ) else $error("mu-law negative full scale wrong");

   a_alaw_full_pos: assert property (
      (adc_law == LAW_A && adc_data == 16'h7FFF)
      |-> (enc_word == 16'hAA00)
   ) else $error("a-law positive full scale wrong");

   a_mu_decode_max: assert property (
      (rx_take && dac_law == LAW_MU && rx_data[15:8] == 8'h80)
      |=> (dac_data == 16'h7D7C)
   ) else $error("mu-law decode of largest code wrong");

   a_alaw_decode_neg: assert property (
      (rx_take && dac_law == LAW_A && rx_data[15:8] == 8'h2A)
      |=> (dac_data == 16'h8200)
   ) else $error("a-law decode of largest negative code wrong");

   c_mu_transmit: cover property (
      adc_valid && adc_ready && adc_law == LAW_MU ##[1:20] tx_valid
   );
   c_a_receive: cover property (
      rx_take && dac_law == LAW_A ##1 dac_valid && dac_ready
   );
   c_fifo_full: cover property (
      adc_valid && !adc_ready
   );
   c_word8_on: cover property (
      ctrl_hit && reg_wdata[5] ##2 word_bits == 6'h08
   );
   c_dac_stall: cover property (
      dac_valid && !dac_ready ##1 dac_valid && dac_ready
   );
endmodule : gcu_top

// [hw/gcu_defs.svh]
// constants for the companding unit: offsets, fields, resets, codec figures
`ifndef GCU_DEFS_SVH
`define GCU_DEFS_SVH
// ==========================================================
// register map
`define GCU_CTRL_ADDR   7'h05
`define GCU_CTRL_RESET  6'h00
`define GCU_LOOP_BIT    0
`define GCU_ADC_LO      1
`define GCU_ADC_HI      2
`define GCU_DAC_LO      3
`define GCU_DAC_HI      4
`define GCU_B8_BIT      5
// ==========================================================
// codec figures
`define GCU_MU_CLIP     14'h1FDE
`define GCU_MU_BIAS     14'h0021
`define GCU_MU_DBIAS    16'h0084
`define GCU_A_SEG1      16'h0108
`define GCU_A_HALF      16'h0008
`define GCU_MU_FLIP     8'hFF
`define GCU_A_FLIP      8'h55
// ==========================================================
// serial word lengths in bits
`define GCU_BITS_8      6'h08
`define GCU_BITS_16     6'h10
`define GCU_BITS_20     6'h14
`define GCU_BITS_24     6'h18
`define GCU_BITS_32     6'h20
`endif

// [hw/gcu_pkg.sv]
// types shared by the companding unit
package gcu_pkg;
   // ==========================================================
   // law selection codes of each compand select field
   typedef enum logic [1:0] {
      LAW_OFF = 2'b00,
      LAW_RSV = 2'b01,
      LAW_MU  = 2'b10,
      LAW_A   = 2'b11
   } gcu_law_t;
endpackage : gcu_pkg

// [hw/gcu_fifo.sv]
// parameterised fifo with a registered output stage
module gcu_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 16
) (
   input  wire logic             mclk,
   input  wire logic             nrst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr;
   logic [AW-1:0]    rptr;
   logic [AW:0]      cnt;
   logic [AW-1:0]    next_wptr;
   logic [AW-1:0]    next_rptr;
   logic [AW:0]      next_cnt;
   logic             next_valid;
   logic             push;
   logic             pop;

   // ==========================================================
   // pointer and level update
   assign in_ready = (cnt != (AW+1)'(DEPTH));
   assign push     = in_valid && in_ready;
   assign pop      = (cnt != '0) && (!out_valid || out_ready);
   always_comb begin
      next_wptr  = push ? AW'(wptr + 1'b1) : wptr;
      next_rptr  = pop ? AW'(rptr + 1'b1) : rptr;
      next_cnt   = cnt + (AW+1)'(push) - (AW+1)'(pop);
      next_valid = pop || (out_valid && !out_ready);
   end

   // the head word moves into a register so the reader sees flop data
   always_ff @(posedge mclk) begin
      if (!nrst) begin
         wptr      <= '0;
         rptr      <= '0;
         cnt       <= '0;
         out_valid <= 1'b0;
         out_data  <= '0;
      end else begin
         wptr      <= next_wptr;
         rptr      <= next_rptr;
         cnt       <= next_cnt;
         out_valid <= next_valid;
         if (pop) begin
            out_data <= mem[rptr];
         end
      end
   end

   // storage has no reset, only written words are ever read
   always_ff @(posedge mclk) begin
      if (push) begin
         mem[wptr] <= in_data;
      end
   end
endmodule : gcu_fifo

// [hw/gcu_law.sv]
// combinational g.711 encoder and decoder
module gcu_law
   import gcu_pkg::*;
(
   input  wire gcu_pkg::gcu_law_t tx_law,
   input  wire logic [15:0]       lin_in,
   output logic       [15:0]      enc_out,
   input  wire gcu_pkg::gcu_law_t rx_law,
   input  wire logic [15:0]       code_in,
   output logic       [15:0]      dec_out
);
`include "gcu_defs.svh"

   // ==========================================================
   // mu-law encode of the top 14 bits
   function automatic logic [7:0] mu_enc(input logic [15:0] x);
      logic [13:0] mag;
      logic [13:0] sh;
      logic [2:0]  seg;
      mag = x[15] ? 14'(~x[15:2] + 14'h1) : x[15:2];
      if (mag > `GCU_MU_CLIP) mag = `GCU_MU_CLIP;
      mag = mag + `GCU_MU_BIAS;
      seg = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (mag[i+5]) seg = 3'(i);
      end
      sh = mag >> ({1'b0, seg} + 4'h1);
      return {x[15], seg, sh[3:0]} ^ `GCU_MU_FLIP;
   endfunction : mu_enc

   // a-law encode of the top 13 bits
   function automatic logic [7:0] a_enc(input logic [15:0] x);
      logic [11:0] mag;
      logic [11:0] sh;
      logic [2:0]  seg;
      mag = x[15] ? ~x[14:3] : x[14:3];
      seg = 3'h0;
      for (int i = 5; i < 12; i++) begin
         if (mag[i]) seg = 3'(i - 4);
      end
      sh = (seg == 3'h0) ? (mag >> 1) : (mag >> seg);
      return {~x[15], seg, sh[3:0]} ^ `GCU_A_FLIP;
   endfunction : a_enc

   // mu-law decode to 16-bit scale
   function automatic logic [15:0] mu_dec(input logic [7:0] c);
      logic [7:0]  u;
      logic [15:0] t;
      u = c ^ `GCU_MU_FLIP;
      t = (16'({u[3:0], 3'b000}) + `GCU_MU_DBIAS) << u[6:4];
      return u[7] ? (`GCU_MU_DBIAS - t) : (t - `GCU_MU_DBIAS);
   endfunction : mu_dec

   // a-law decode to 16-bit scale
   function automatic logic [15:0] a_dec(input logic [7:0] c);
      logic [7:0]  a;
      logic [15:0] t;
      a = c ^ `GCU_A_FLIP;
      t = 16'({a[3:0], 4'h0});
      if (a[6:4] == 3'h0) t = t + `GCU_A_HALF;
      else t = (t + `GCU_A_SEG1) << (a[6:4] - 3'h1);
      return a[7] ? t : 16'(-t);
   endfunction : a_dec

   // ==========================================================
   // code sits msb-aligned so an msb-first shifter sends it first
   always_comb begin
      case (tx_law)
         LAW_MU:  enc_out = {mu_enc(lin_in), 8'h00};
         LAW_A:   enc_out = {a_enc(lin_in), 8'h00};
         default: enc_out = lin_in;
      endcase
      case (rx_law)
         LAW_MU:  dec_out = mu_dec(code_in[15:8]);
         LAW_A:   dec_out = a_dec(code_in[15:8]);
         default: dec_out = code_in;
      endcase
   end
endmodule : gcu_law

// [tb/gcu_far_model.sv]
// far side model: serial port sink of tx words, source of rx words
module gcu_far_model (
   input  wire logic        mclk,
   input  wire logic        tx_valid,
   output logic             tx_ready,
   input  wire logic [15:0] tx_data,
   output logic             rx_valid,
   input  wire logic        rx_ready,
   output logic      [15:0] rx_data
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [15:0] got[$];
   int          mode = 0; // 0 prompt, 1 halted, 2 slow
   int          tick = 0;
   int          stuck = 0; // sends that never found rx_ready
   // ==========================================================
   // sink side
   initial begin
      tx_ready = 1'b0;
      rx_valid = 1'b0;
      rx_data  = 16'h0000;
   end
   // a slow port only takes every other cycle, so the queue backs up
   always @(posedge mclk) begin
      if (tx_valid && tx_ready) got.push_back(tx_data);
      tick <= tick + 1;
      #1 tx_ready = mode == 0 || (mode == 2 && tick[0]);
   end
   // ==========================================================
   // source side: word held until the edge that finds rx_ready high
   task automatic send(input logic [15:0] w);
      int n;
      n = 0;
      rx_valid = 1'b1;
      rx_data  = w;
      while (!rx_ready && n < 200) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (!rx_ready) stuck++;
      @(posedge mclk);
      #1;
   endtask : send
   // released bus shows no stale word
   task automatic idle;
      rx_valid = 1'b0;
      rx_data  = ~rx_data;
   endtask : idle
endmodule : gcu_far_model

// [tb/gcu_top_test.sv]
// self-checking bench for the companding unit
`include "gcu_defs.svh"
module gcu_top_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int DEPTH = 16;
   logic        mclk, nrst, reg_wr, adc_valid, dac_ready;
   logic        adc_ready, tx_valid, tx_ready, rx_valid, rx_ready;
   logic        dac_valid, adc_dac_loop;
   logic [6:0]  reg_addr;
   logic [8:0]  reg_wdata, reg_rdata;
   logic [1:0]  serial_word_length;
   logic [5:0]  word_bits;
   logic [15:0] adc_data, tx_data, rx_data, dac_data;
   logic [15:0] dac_got[$];
   int          errors = 0;
   int          cmp_count = 0;
   // ==========================================================
   // design and far side
   gcu_top #(.FIFO_DEPTH(DEPTH)) uut (
      .mclk(mclk), .nrst(nrst), .reg_wr(reg_wr), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .serial_word_length(serial_word_length), .word_bits(word_bits),
      .adc_dac_loop(adc_dac_loop), .adc_valid(adc_valid),
      .adc_ready(adc_ready), .adc_data(adc_data), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_data(tx_data), .rx_valid(rx_valid),
      .rx_ready(rx_ready), .rx_data(rx_data), .dac_valid(dac_valid),
      .dac_ready(dac_ready), .dac_data(dac_data));
   gcu_far_model far (
      .mclk(mclk), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready),
      .rx_data(rx_data));
   // dac sink ready except during t_stall; words collected for later comparison
   always @(posedge mclk) begin
      if (dac_valid && dac_ready) dac_got.push_back(dac_data);
   end
   // ==========================================================
   // reference laws, sign first then segment then mantissa
   function automatic logic [7:0] enc(logic is_a, logic [15:0] s);
      int         v, sg;
      logic [7:0] m;
      m = is_a ? 8'hD5 : 8'hFF;
      v = is_a ? $signed(s[15:3]) : $signed(s[15:2]);
      if (v < 0) begin
         v = is_a ? -v - 1 : -v;
         m = m ^ 8'h80;
      end
      if (!is_a) v = (v > 8158 ? 8158 : v) + 33;
      sg = 0;
      for (int i = 0; i < 7; i++) begin
         if (v >= ((is_a ? 32 : 64) << i)) sg = i + 1;
      end
      v = (is_a && sg == 0) ? v >> 1 : v >> (sg + !is_a);
      return {1'b0, sg[2:0], v[3:0]} ^ m;
   endfunction : enc
   function automatic logic [15:0] dec(logic is_a, logic [7:0] c);
      int t, sg;
      c = c ^ (is_a ? 8'h55 : 8'hFF);
      sg = c[6:4];
      if (is_a) t = (c[3:0] << 4) + (sg == 0 ? 8 : 264);
      else t = (c[3:0] << 3) + 132;
      t = is_a ? (sg > 1 ? t << (sg - 1) : t) : (t << sg) - 132;
      // a-law sets the sign bit for positive, mu-law for negative
      return (c[7] == is_a) ? t[15:0] : -t[15:0];
   endfunction : dec
   // ==========================================================
   // shared drivers and checks
   task automatic chk(input logic [15:0] got, exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk
   task automatic give_verdict;
      if (errors == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict
   task automatic wait_q(ref logic [15:0] q[$], input int n);
      int k;
      k = 0;
      while (q.size() < n && k < 400) begin
         @(posedge mclk);
         #1;
         k++;
      end
      if (q.size() < n) begin
         errors++;
         give_verdict();
      end
   endtask : wait_q
   task automatic reg_write(input logic [6:0] a, input logic [8:0] d);
      reg_wr    = 1'b1;
      reg_addr  = a;
      reg_wdata = d;
      @(posedge mclk);
      #1;
      reg_wr = 1'b0;
   endtask : reg_write
   task automatic reg_read(input logic [6:0] a, output logic [8:0] d);
      reg_addr = a;
      @(posedge mclk);
      #1;
      d = reg_rdata;
   endtask : reg_read
   // sample held until an edge finds room; valid left up for the next
   task automatic push(input logic [15:0] s);
      int n;
      n = 0;
      adc_valid = 1'b1;
      adc_data  = s;
      while (!adc_ready && n < 200) begin
         @(posedge mclk);
         #1;
         n++;
      end
      if (!adc_ready) begin
         errors++;
         give_verdict();
      end
      @(posedge mclk);
      #1;
   endtask : push
   // ==========================================================
   // scenarios
   task automatic t_reset;
      logic [8:0] rd;
      reg_read(`GCU_CTRL_ADDR, rd);
      chk(16'(rd), 16'h0000, "ctrl reset");
      chk(16'(word_bits), 16'h0010, "len reset");
      chk({14'h0, tx_valid, dac_valid}, 16'h0000, "valid reset");
   endtask : t_reset
   task automatic t_regs;
      logic [8:0]  rd;
      logic [15:0] wl[4] = '{16'h0010, 16'h0014, 16'h0018, 16'h0020};
      reg_write(`GCU_CTRL_ADDR, 9'h1FF);
      reg_read(`GCU_CTRL_ADDR, rd);
      chk(16'(rd), 16'h003F, "top bits");
      chk(16'(adc_dac_loop), 16'h0001, "loop bit");
      reg_write(7'h06, 9'h000);
      reg_read(7'h06, rd);
      chk(16'(rd), 16'h0000, "unmapped");
      reg_read(`GCU_CTRL_ADDR, rd);
      chk(16'(rd), 16'h003F, "kept");
      for (int w = 0; w < 4; w++) begin
         serial_word_length = w[1:0];
         reg_write(`GCU_CTRL_ADDR, 9'h000);
         reg_read(`GCU_CTRL_ADDR, rd);
         chk(16'(word_bits), wl[w], "length");
         reg_write(`GCU_CTRL_ADDR, 9'h020);
         reg_read(`GCU_CTRL_ADDR, rd);
         chk(16'(word_bits), 16'(`GCU_BITS_8), "eight");
      end
   endtask : t_regs
   // every select code on both paths; 01 must act as off
   task automatic t_laws;
      logic [15:0] smp[6] = '{16'h0000, 16'h0048, 16'h7FFC, 16'h8000,
                              16'hFDF0, 16'h0100};
      logic [7:0]  cod[7] = '{8'h00, 8'h55, 8'hD5, 8'hFF, 8'h80, 8'h2A, 8'h7F};
      logic [8:0]  rd;
      logic [15:0] e;
      for (int l = 0; l < 4; l++) begin
         reg_write(`GCU_CTRL_ADDR, 9'(l * 10));
         reg_read(`GCU_CTRL_ADDR, rd);
         chk(16'(rd), 16'(l * 10), "ctrl");
         foreach (smp[i]) push(smp[i]);
         adc_valid = 1'b0;
         wait_q(far.got, 6);
         foreach (smp[i]) begin
            e = l > 1 ? {enc(l == 3, smp[i]), 8'h00} : smp[i];
            chk(far.got[i], e, "tx");
         end
         foreach (cod[i]) far.send({cod[i], 8'h3C});
         far.idle();
         if (far.stuck != 0) begin
            errors++;
            give_verdict();
         end
         wait_q(dac_got, 7);
         foreach (cod[i]) begin
            e = l > 1 ? dec(l == 3, cod[i]) : {cod[i], 8'h3C};
            chk(dac_got[i], e, "rx");
         end
         far.got.delete();
         dac_got.delete();
      end
   endtask : t_laws
   // a-law word held at the dac output while the sink stalls
   task automatic t_stall;
      logic [15:0] e;
      e = dec(1'b1, 8'h2A);
      dac_ready = 1'b0;
      far.send(16'h2A00);
      far.idle();
      repeat (3) @(posedge mclk);
      #1;
      chk({15'h0, dac_valid}, 16'h0001, "stall valid");
      chk(dac_data, e, "stall data");
      dac_ready = 1'b1;
      wait_q(dac_got, 1);
      chk(dac_got[0], e, "stall out");
      dac_got.delete();
   endtask : t_stall
   // queue filled against a halted port, then drained slowly in order
   task automatic t_fifo;
      int n;
      far.mode = 1;
      reg_write(`GCU_CTRL_ADDR, 9'h000);
      n = 0;
      adc_valid = 1'b1;
      while (adc_ready && n < 40) begin
         adc_data = 16'h1000 + 16'(n);
         @(posedge mclk);
         #1;
         n++;
      end
      adc_valid = 1'b0;
      chk(16'(n), 16'(DEPTH + 1), "capacity");
      far.mode = 2;
      wait_q(far.got, DEPTH + 1);
      foreach (far.got[i]) chk(far.got[i], 16'h1000 + 16'(i), "order");
   endtask : t_fifo
   // ==========================================================
   // clock and main sequence
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   initial begin
      nrst = 1'b0;
      reg_wr = 1'b0;
      reg_addr = 7'h00;
      reg_wdata = 9'h000;
      serial_word_length = 2'b00;
      adc_valid = 1'b0;
      adc_data = 16'h0000;
      dac_ready = 1'b1;
      repeat (2) @(posedge mclk);
      #1;
      nrst = 1'b1;
      t_reset();
      t_regs();
      t_laws();
      t_stall();
      t_fifo();
      give_verdict();
   end
endmodule : gcu_top_test
